// ### cex_core.sv
/*
 * Execute core for a subset of the instruction set: branches, calls,
 * bit set and test, clears, increments, OR, shifts, moves, watchdog clear
 * and indirect reads.  Each instruction cycle is four clocks.
 * Assumes program memory and data file answer one clock after a read.
 */
// Decided for this implementation: the strobed register port and the register offsets.
`include "cex_defs.svh"

module cex_core #(
	parameter int STACK_DEPTH = 16,
	parameter int STACK_AW    = 4,
	parameter int WDT_PRE_W   = 8,
	parameter int WDT_CNT_W   = 8
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	output logic      [14:0] prog_addr,
	output logic             prog_re,
	input  wire logic [13:0] prog_data,
	output logic      [15:0] file_addr,
	output logic             file_re,
	output logic             file_we,
	output logic      [7:0]  file_wdata,
	input  wire logic [7:0]  file_rdata,
	output logic             watchdog_clear,
	output logic             timeout_flag_n,
	output logic             powerdown_flag_n
);
	import cex_pkg::*;

	logic [1:0]  ph_r;         // Phase within the instruction cycle.
	logic        run_r;        // Software run enable.
	logic        live_r;       // This instruction cycle executes.
	logic [1:0]  dead_r;       // No-op cycles still to spend.
	logic        pen_r;        // Current instruction owes a pointer penalty.
	logic [7:0]  w_r;          // Working register.
	logic        c_r;          // Carry flag.
	logic        z_r;          // Zero flag.
	logic [6:0]  page_latch;   // Upper program counter source.
	logic [15:0] ptr0_r;       // File select pointer 0.
	logic [15:0] ptr1_r;       // File select pointer 1.
	logic [14:0] pc_r;         // Address of the instruction in flight.
	logic [STACK_AW-1:0] sp_r; // Next free stack slot.
	logic [13:0] ir_r;         // Opcode in flight.
	cex_op_t     op_r;         // Decoded class of ir_r.
	logic [14:0] top_of_return_stack;
	logic        wdt_timeout;

	// Phase divider: ph_r == exec is the instruction cycle enable.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ph_r <= 2'h0;
		end else begin
			ph_r <= ph_r + 2'h1;
		end
	end

	logic dec_en;   // Decode phase of a live cycle.
	logic exec_en;  // Execute phase of a live cycle.
	logic cyc_end;  // Last clock of any instruction cycle.
	logic idle;     // Core stopped, software may load state.
	assign cyc_end = (ph_r == `CEX_PH_EXEC);
	assign dec_en  = live_r && (ph_r == `CEX_PH_DECODE);
	assign exec_en = live_r && cyc_end;
	assign idle    = !run_r && !live_r;

	// Opcode classifier; the first match wins, patterns do not overlap.
	function automatic cex_op_t decode(input logic [13:0] o);
		casez (o)
			`CEX_PAT_RELATIVE_BRANCH:   decode = relative_branch_op;
			`CEX_PAT_BRANCH_BY_WORKING: decode = branch_by_working_op;
			`CEX_PAT_CALL_BY_WORKING:   decode = call_by_working_op;
			`CEX_PAT_WATCHDOG_CLEAR:    decode = watchdog_clear_op;
			`CEX_PAT_CALL:              decode = call_op;
			`CEX_PAT_ABSOLUTE_JUMP:     decode = absolute_jump_op;
			`CEX_PAT_BIT_SET:           decode = bit_set_op;
			`CEX_PAT_BIT_TEST_SKIP_SET: decode = bit_test_skip_set_op;
			`CEX_PAT_COMPLEMENT_FILE:   decode = complement_file_op;
			`CEX_PAT_CLEAR_FILE:        decode = clear_file_op;
			`CEX_PAT_CLEAR_WORKING:     decode = clear_working_op;
			`CEX_PAT_DECREMENT_FILE:    decode = decrement_file_op;
			`CEX_PAT_INCREMENT_FILE:    decode = increment_file_op;
			`CEX_PAT_DECREMENT_SKIP:    decode = decrement_skip_zero_op;
			`CEX_PAT_INCREMENT_SKIP:    decode = increment_skip_zero_op;
			`CEX_PAT_OR_LITERAL:        decode = or_literal_op;
			`CEX_PAT_OR_FILE:           decode = or_file_op;
			`CEX_PAT_LEFT_SHIFT:        decode = logical_left_shift_op;
			`CEX_PAT_RIGHT_SHIFT:       decode = logical_right_shift_op;
			`CEX_PAT_MOVE_FILE:         decode = move_file_op;
			`CEX_PAT_INDIRECT_READ:     decode = indirect_read_op;
			`CEX_PAT_INDEXED_READ:      decode = indexed_read_op;
			default:                    decode = op_none_t_val;
		endcase
	endfunction

	cex_op_t     dec_op;    // Class of the opcode arriving now.
	logic [15:0] ea;        // Effective data address.
	logic        rd_need;   // The instruction reads the file.
	logic        use_ptr;   // The access goes through a pointer.
	logic        ptr_sel;   // Which pointer.
	logic        ptr_upd;   // Pointer is stepped by this instruction.
	logic [15:0] ptr_cur;   // Value of the chosen pointer.
	logic [15:0] ptr_step;  // Pointer after its one-step update.

	// Address generation during the decode phase.
	always_comb begin
		dec_op   = decode(prog_data);
		rd_need  = 1'b1;
		use_ptr  = 1'b0;
		ptr_upd  = 1'b0;
		ptr_sel  = prog_data[0];
		ea       = {9'h000, prog_data[6:0]};
		case (dec_op)
			indirect_read_op: ptr_sel = prog_data[2];
			indexed_read_op:  ptr_sel = prog_data[6];
			default:          ptr_sel = prog_data[0];
		endcase
		ptr_cur  = ptr_sel ? ptr1_r : ptr0_r;
		// Natural 16-bit arithmetic wraps at both ends.
		ptr_step = prog_data[0] ? ptr_cur - 16'h0001
		                        : ptr_cur + 16'h0001;
		case (dec_op)
			indirect_read_op: begin
				// Mode 0x is pre, 1x post; x0 up, x1 down.
				use_ptr = 1'b1;
				ptr_upd = 1'b1;
				ea      = prog_data[1] ? ptr_cur : ptr_step;
			end
			indexed_read_op: begin
				// Signed six-bit offset; the pointer is kept.
				use_ptr = 1'b1;
				ea      = ptr_cur + {{10{prog_data[5]}}, prog_data[5:0]};
			end
			relative_branch_op, branch_by_working_op, call_op,
			call_by_working_op, absolute_jump_op, watchdog_clear_op,
			clear_working_op, or_literal_op, op_none_t_val: begin
				rd_need = 1'b0;
			end
			default: begin
				// The indirect port has no storage of its own.
				if (prog_data[6:1] == 6'h00) begin
					use_ptr = 1'b1;
					ea      = ptr_cur;
				end
			end
		endcase
	end

	// Instruction and address capture in the decode phase.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ir_r      <= 14'h0000;
			op_r      <= op_none_t_val;
			file_addr <= 16'h0000;
			pen_r     <= 1'b0;
		end else if (dec_en) begin
			ir_r      <= prog_data;
			op_r      <= dec_op;
			file_addr <= ea;
			pen_r     <= use_ptr && ptr_cur[15];
		end
	end

	// File read strobe: one clock, in the phase after decode.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			file_re <= 1'b0;
		end else begin
			file_re <= dec_en && rd_need;
		end
	end

	logic [7:0]  res;       // Result byte.
	logic        to_w;      // Result goes to the working register.
	logic        to_f;      // Result goes back to the file.
	logic        z_upd;     // Zero flag is affected.
	logic        c_upd;     // Carry flag is affected.
	logic        c_val;     // New carry.
	logic        taken;     // Skip or program counter change.
	logic        push;      // Return address is pushed.
	logic        wclr;      // Watchdog clear.
	logic [14:0] pc_inc;    // Incremented program counter.
	logic [14:0] tgt;       // Next instruction address.
	logic        dsel;      // Destination select of file forms.
	assign pc_inc = pc_r + 15'h0001;
	assign dsel   = ir_r[7];

	// Execute: flags default to untouched for every class.
	always_comb begin
		res   = 8'h00;
		to_w  = 1'b0;
		to_f  = 1'b0;
		z_upd = 1'b0;
		c_upd = 1'b0;
		c_val = c_r;
		taken = 1'b0;
		push  = 1'b0;
		wclr  = 1'b0;
		tgt   = pc_inc;
		case (op_r)
			relative_branch_op: begin
				taken = 1'b1;
				tgt   = pc_inc + {{6{ir_r[8]}}, ir_r[8:0]};
			end
			branch_by_working_op: begin
				taken = 1'b1;
				tgt   = pc_inc + {7'h00, w_r};
			end
			call_op: begin
				taken = 1'b1;
				push  = 1'b1;
				tgt   = {page_latch[6:3], ir_r[10:0]};
			end
			absolute_jump_op: begin
				// Upper bits from latch 6:3, no stack push.
				taken = 1'b1;
				tgt   = {page_latch[6:3], ir_r[10:0]};
			end
			call_by_working_op: begin
				taken = 1'b1;
				push  = 1'b1;
				tgt   = {page_latch, w_r};
			end
			bit_test_skip_set_op: begin
				// Fetch follows execute, so a skip steps over a word.
				taken = file_rdata[ir_r[9:7]];
				tgt   = taken ? pc_r + 15'h0002 : pc_inc;
			end
			bit_set_op: begin
				res  = file_rdata | (8'h01 << ir_r[9:7]);
				to_f = 1'b1;
			end
			watchdog_clear_op: begin
				wclr = 1'b1;
			end
			complement_file_op: begin
				res   = ~file_rdata;
				to_w  = !dsel;
				to_f  = dsel;
				z_upd = 1'b1;
			end
			clear_file_op: begin
				to_f  = 1'b1;
				z_upd = 1'b1;
			end
			clear_working_op: begin
				to_w  = 1'b1;
				z_upd = 1'b1;
			end
			increment_file_op, decrement_file_op: begin
				res   = (op_r == increment_file_op) ? file_rdata + 8'h01
				                                    : file_rdata - 8'h01;
				to_w  = !dsel;
				to_f  = dsel;
				z_upd = 1'b1;
			end
			increment_skip_zero_op, decrement_skip_zero_op: begin
				res   = (op_r == increment_skip_zero_op)
				        ? file_rdata + 8'h01 : file_rdata - 8'h01;
				to_w  = !dsel;
				to_f  = dsel;
				taken = (res == 8'h00);
				tgt   = taken ? pc_r + 15'h0002 : pc_inc;
			end
			or_literal_op: begin
				res   = w_r | ir_r[7:0];
				to_w  = 1'b1;
				z_upd = 1'b1;
			end
			or_file_op: begin
				res   = w_r | file_rdata;
				to_w  = !dsel;
				to_f  = dsel;
				z_upd = 1'b1;
			end
			logical_left_shift_op: begin
				res   = {file_rdata[6:0], 1'b0};
				c_upd = 1'b1;
				c_val = file_rdata[7];
				to_w  = !dsel;
				to_f  = dsel;
				z_upd = 1'b1;
			end
			logical_right_shift_op: begin
				res   = {1'b0, file_rdata[7:1]};
				c_upd = 1'b1;
				c_val = file_rdata[0];
				to_w  = !dsel;
				to_f  = dsel;
				z_upd = 1'b1;
			end
			move_file_op: begin
				res   = file_rdata;
				to_w  = !dsel;
				to_f  = dsel;
				z_upd = 1'b1;
			end
			indirect_read_op, indexed_read_op: begin
				res   = file_rdata;
				to_w  = 1'b1;
				z_upd = 1'b1;
			end
			default: begin
				tgt = pc_inc;
			end
		endcase
	end

	// Cycle bookkeeping: a taken skip or jump, and a pointer penalty,
	// each add one dead cycle executed as a no-op.
	logic [1:0] dead_nxt;
	always_comb begin
		dead_nxt = dead_r;
		if (exec_en) begin
			dead_nxt = {1'b0, taken} + {1'b0, pen_r};
		end else if (dead_r != 2'h0) begin
			dead_nxt = dead_r - 2'h1;
		end
	end

	// Live and dead cycle tracking at every instruction cycle end.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			dead_r <= 2'h0;
			live_r <= 1'b0;
		end else if (cyc_end) begin
			dead_r <= dead_nxt;
			live_r <= run_r && (dead_nxt == 2'h0);
		end
	end

	// Program fetch: one-clock strobe at the start of a live cycle.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			prog_re   <= 1'b0;
			prog_addr <= `CEX_PC_RST;
		end else begin
			prog_re <= cyc_end && run_r && (dead_nxt == 2'h0);
			if (cyc_end) begin
				prog_addr <= exec_en ? tgt : pc_r;
			end
		end
	end

	// Program counter: software may load it only while idle.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pc_r <= `CEX_PC_RST;
		end else if (exec_en) begin
			pc_r <= tgt;
		end else if (idle && reg_wr && reg_addr == `CEX_REG_PC) begin
			pc_r <= reg_wdata[14:0];
		end
	end

	// File write-back, visible in the clock after execute.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			file_we    <= 1'b0;
			file_wdata <= 8'h00;
		end else begin
			file_we <= exec_en && to_f;
			if (exec_en) begin
				file_wdata <= res;
			end
		end
	end

	// Working register and arithmetic flags.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			w_r <= `CEX_WORK_RST;
			c_r <= 1'b0;
			z_r <= 1'b0;
		end else if (exec_en) begin
			if (to_w) begin
				w_r <= res;
			end
			if (z_upd) begin
				z_r <= (res == 8'h00);
			end
			if (c_upd) begin
				c_r <= c_val;
			end
		end else if (idle && reg_wr) begin
			if (reg_addr == `CEX_REG_WORK) begin
				w_r <= reg_wdata[7:0];
			end
			if (reg_addr == `CEX_REG_STATUS) begin
				c_r <= reg_wdata[`CEX_ST_CARRY];
				z_r <= reg_wdata[`CEX_ST_ZERO];
			end
		end
	end

	// Page latch and control; the latch is loaded only by software here.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			page_latch <= `CEX_LATCH_RST;
			run_r      <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == `CEX_REG_CTRL) begin
				run_r <= reg_wdata[`CEX_CTRL_RUN];
			end
			if (idle && reg_addr == `CEX_REG_LATCH) begin
				page_latch <= reg_wdata[6:0];
			end
		end
	end

	// Pointers: stepped in decode by the indirect read.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ptr0_r <= `CEX_PTR_RST;
			ptr1_r <= `CEX_PTR_RST;
		end else if (dec_en && ptr_upd) begin
			if (ptr_sel) begin
				ptr1_r <= ptr_step;
			end else begin
				ptr0_r <= ptr_step;
			end
		end else if (idle && reg_wr) begin
			if (reg_addr == `CEX_REG_PTR0) begin
				ptr0_r <= reg_wdata;
			end
			if (reg_addr == `CEX_REG_PTR1) begin
				ptr1_r <= reg_wdata;
			end
		end
	end

	// Return stack pointer; wraps silently when more than full.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sp_r <= '0;
		end else if (exec_en && push) begin
			sp_r <= sp_r + 1'b1;
		end
	end

	// Return address storage; its read port shows the top entry.
	cex_stack_mem #(
		.WIDTH (15),
		.DEPTH (STACK_DEPTH),
		.AW    (STACK_AW)
	) u_stack (
		.clk   (clk),
		.rstn  (rstn),
		.we    (exec_en && push),
		.waddr (sp_r),
		.wdata (pc_inc),
		.raddr (sp_r - 1'b1),
		.rdata (top_of_return_stack)
	);

	// Watchdog clear pulse, registered for the port and the counter.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			watchdog_clear <= 1'b0;
		end else begin
			watchdog_clear <= exec_en && wclr;
		end
	end

	cex_watchdog #(
		.PRE_W   (WDT_PRE_W),
		.CNT_W   (WDT_CNT_W)
	) u_wdt (
		.clk     (clk),
		.rstn    (rstn),
		.clr     (watchdog_clear),
		.timeout (wdt_timeout)
	);

	// Active-low flags: a timeout at the same clock wins over the clear.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			timeout_flag_n   <= 1'b1;
			powerdown_flag_n <= 1'b1;
		end else begin
			if (wdt_timeout) begin
				timeout_flag_n <= 1'b0;
			end else if (exec_en && wclr) begin
				timeout_flag_n <= 1'b1;
			end
			if (exec_en && wclr) begin
				powerdown_flag_n <= 1'b1;
			end
		end
	end

	// Read data stand only in the clock after the read strobe.
	always_ff @(posedge clk) begin
		if (!rstn || !reg_rd) begin
			reg_rdata <= 16'h0000;
		end else begin
			case (reg_addr)
				`CEX_REG_CTRL:   reg_rdata <= {13'h0000, dead_r, run_r};
				`CEX_REG_WORK:   reg_rdata <= {8'h00, w_r};
				`CEX_REG_STATUS: reg_rdata <= {11'h000, timeout_flag_n,
				                   powerdown_flag_n, z_r, 1'b0, c_r};
				`CEX_REG_LATCH:  reg_rdata <= {9'h000, page_latch};
				`CEX_REG_PTR0:   reg_rdata <= ptr0_r;
				`CEX_REG_PTR1:   reg_rdata <= ptr1_r;
				`CEX_REG_PC:     reg_rdata <= {1'b0, pc_r};
				`CEX_REG_TOS:    reg_rdata <= {1'b0, top_of_return_stack};
				default:         reg_rdata <= 16'h0000;
			endcase
		end
	end
endmodule // cex_core

// ### cex_defs.svh
/*
 * Constants of the instruction execute block: opcode patterns, register
 * offsets, field positions, reset values and phase numbers.
 * Assumes it is included by its bare name from the package and the core.
 */
// Operation
// - Relative branch goes to PC+1+signed k9
// - Bit test skips next instruction when set
// - Branch by working goes to PC+1+W
// - Bit set forces one bit, flags untouched
// - Destination bit selects working or file
// - Call pushes PC+1, loads k11 and latch
// - Jump loads k11 and latch, no push
// - Call by working pushes, loads latch:W
// - Watchdog clear zeroes counter, sets both flags
// - Complement writes inverse, updates zero
// - Clear file writes zero, sets zero flag
// - Clear working zeroes W, sets zero flag
// - Increment and decrement update zero only
// - Skip forms change no flag, skip on zero
// - Or literal into W, updates zero
// - Or file with W, updates zero
// - Left shift: bit7 to carry, zero in
// - Right shift: bit0 to carry, zero in
// - Move file copies and updates zero
// - Indirect read mode: pre/post inc/dec
// - Indexed read uses pointer plus signed offset
// - Indirect port reaches pointer's address
// - Pointer wraps at both ends
// - Pointer msb set costs one extra cycle
// - Skip or PC change costs a no-op cycle
`ifndef CEX_DEFS_SVH
`define CEX_DEFS_SVH

// Opcode patterns, matched with casez.
`define CEX_PAT_RELATIVE_BRANCH   14'b11_001?_????_????
`define CEX_PAT_BRANCH_BY_WORKING 14'h000b
`define CEX_PAT_CALL_BY_WORKING   14'h000a
`define CEX_PAT_WATCHDOG_CLEAR    14'h0064
`define CEX_PAT_CALL              14'b10_0???_????_????
`define CEX_PAT_ABSOLUTE_JUMP     14'b10_1???_????_????
`define CEX_PAT_BIT_SET           14'b01_01??_????_????
`define CEX_PAT_BIT_TEST_SKIP_SET 14'b01_11??_????_????
`define CEX_PAT_COMPLEMENT_FILE   14'b00_1001_????_????
`define CEX_PAT_CLEAR_FILE        14'b00_0001_1???_????
`define CEX_PAT_CLEAR_WORKING     14'b00_0001_0000_00??
`define CEX_PAT_DECREMENT_FILE    14'b00_0011_????_????
`define CEX_PAT_INCREMENT_FILE    14'b00_1010_????_????
`define CEX_PAT_DECREMENT_SKIP    14'b00_1011_????_????
`define CEX_PAT_INCREMENT_SKIP    14'b00_1111_????_????
`define CEX_PAT_OR_LITERAL        14'b11_1000_????_????
`define CEX_PAT_OR_FILE           14'b00_0100_????_????
`define CEX_PAT_LEFT_SHIFT        14'b11_0101_????_????
`define CEX_PAT_RIGHT_SHIFT       14'b11_0110_????_????
`define CEX_PAT_MOVE_FILE         14'b00_1000_????_????
`define CEX_PAT_INDIRECT_READ     14'b00_0000_0001_0???
`define CEX_PAT_INDEXED_READ      14'b11_1111_0???_????

// Register offsets on the software port.
`define CEX_REG_CTRL    4'h0
`define CEX_REG_WORK    4'h1
`define CEX_REG_STATUS  4'h2
`define CEX_REG_LATCH   4'h3
`define CEX_REG_PTR0    4'h4
`define CEX_REG_PTR1    4'h5
`define CEX_REG_PC      4'h6
`define CEX_REG_TOS     4'h7

// Status and control field positions.
`define CEX_ST_CARRY    0
`define CEX_ST_ZERO     2
`define CEX_ST_PWRDN_N  3
`define CEX_ST_TMOUT_N  4
`define CEX_CTRL_RUN    0

// Reset values.
`define CEX_PC_RST      15'h0000
`define CEX_WORK_RST    8'h00
`define CEX_PTR_RST     16'h0000
`define CEX_LATCH_RST   7'h00

// Indirect port file addresses and instruction cycle phases.
`define CEX_F_PORT0     7'h00
`define CEX_F_PORT1     7'h01
`define CEX_PH_DECODE   2'h1
`define CEX_PH_EXEC     2'h3

`endif

// ### cex_pkg.sv
/*
 * Types shared by the instruction execute block.
 * Assumes cex_defs.svh is on the include path.
 */
package cex_pkg;
	`include "cex_defs.svh"

	// Decoded operation class of the instruction in flight.
	typedef enum logic [4:0] {
		op_none_t_val,
		relative_branch_op, branch_by_working_op, call_op,
		call_by_working_op, absolute_jump_op, bit_test_skip_set_op,
		bit_set_op, watchdog_clear_op, complement_file_op,
		clear_file_op, clear_working_op, increment_file_op,
		decrement_file_op, increment_skip_zero_op,
		decrement_skip_zero_op, or_literal_op, or_file_op,
		logical_left_shift_op, logical_right_shift_op, move_file_op,
		indirect_read_op, indexed_read_op
	} cex_op_t;
endpackage

// ### cex_stack_mem.sv
/*
 * Return stack storage: one write port, one read port whose data come
 * from a register.  Assumes the core owns the stack pointer.
 */
module cex_stack_mem #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata
);
	// The array carries no reset; the read port reads mem[raddr] every clock, pushed or not.
	logic [WIDTH-1:0] mem [DEPTH];

	// Write port.
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read port, cleared by reset so the output is defined.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule // cex_stack_mem

// ### cex_watchdog.sv
/*
 * Watchdog counter with its prescaler.  A clear zeroes both.
 * Assumes clr is a one-cycle pulse from the core.
 */
module cex_watchdog #(
	parameter int PRE_W = 8,
	parameter int CNT_W = 8
) (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic clr,
	output logic      timeout
);
	logic [PRE_W-1:0] pre_r;  // Prescaler, the divider of the count rate.
	logic [CNT_W-1:0] cnt_r;  // Watchdog count itself.
	logic             tick;   // One-cycle enable when the prescaler wraps.

	assign tick = &pre_r;

	// Prescaler: cleared by a watchdog clear.
	always_ff @(posedge clk) begin
		if (!rstn || clr) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + 1'b1;
		end
	end

	// Counter: cleared to zero by a watchdog clear.
	always_ff @(posedge clk) begin
		if (!rstn || clr) begin
			cnt_r <= '0;
		end else if (tick) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// Timeout pulses once when the count wraps.
	always_ff @(posedge clk) begin
		if (!rstn || clr) begin
			timeout <= 1'b0;
		end else begin
			timeout <= tick && (&cnt_r);
		end
	end
endmodule // cex_watchdog

// ### cex_assertions.sv
/* Checker for the execute core ports.
   Assumes one clock and a synchronous active-low reset. */
module cex_core_assertions (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [14:0] prog_addr,
	input wire logic        prog_re,
	input wire logic [15:0] file_addr,
	input wire logic        file_re,
	input wire logic        file_we,
	input wire logic        watchdog_clear,
	input wire logic        powerdown_flag_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// A fetch opens a cycle of four clocks at the least.
	fetch_gap_a: assert property (prog_re |=> !prog_re [*3])
		else $error("fetch strobes closer than four clocks");
	// Fetches four clocks apart mean nothing was skipped or taken.
	seq_fetch_a: assert property (prog_re && $past(prog_re, 4)
		|-> prog_addr == $past(prog_addr, 4) + 15'h1)
		else $error("plain instruction did not step the counter");
	read_phase_a: assert property (file_re |-> !prog_re && !file_we)
		else $error("data read overlaps fetch or write");
	// The address must not move in the clock before the write back.
	write_addr_a: assert property (file_we |-> $stable(file_addr))
		else $error("data address moved under the write");
	write_gap_a: assert property (file_we |=> !file_we [*3])
		else $error("data writes closer than four clocks");
	wdt_pulse_a: assert property (watchdog_clear
		|-> prog_re && $past(prog_re, 4))
		else $error("watchdog clear outside its phase");
	wdt_flag_a: assert property (watchdog_clear |-> powerdown_flag_n)
		else $error("power-down flag low after watchdog clear");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside the answer cycle");
endmodule // cex_core_assertions

bind cex_core cex_core_assertions chk_u (.clk(clk), .rstn(rstn),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_addr(prog_addr),
	.prog_re(prog_re), .file_addr(file_addr), .file_re(file_re),
	.file_we(file_we), .watchdog_clear(watchdog_clear),
	.powerdown_flag_n(powerdown_flag_n));

// ### cex_mem_model.sv
/* Program memory and data file seen by the core.
   Assumes answers one clock after each strobe; only low 8 address bits. */
module cex_mem_model (
	input wire logic        clk,
	input wire logic [14:0] prog_addr,
	input wire logic        prog_re,
	output logic     [13:0] prog_data,
	input wire logic [15:0] file_addr,
	input wire logic        file_re,
	input wire logic        file_we,
	input wire logic [7:0]  file_wdata,
	output logic     [7:0]  file_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [13:0] rom [0:255]; // Program words.
	logic [7:0]  ram [0:255]; // Data file.
	initial begin
		prog_data = 14'h0000;
		file_rdata = 8'h00;
	end
	// Outside an answer the lines flip, so stale data cannot pass.
	always @(posedge clk) begin
		prog_data <= prog_re ? rom[prog_addr[7:0]] : ~prog_data;
		file_rdata <= file_re ? ram[file_addr[7:0]] : ~file_rdata;
		if (file_we) begin
			ram[file_addr[7:0]] <= file_wdata;
		end
	end
endmodule // cex_mem_model

// ### test_cpu_instruction_execute_subset.sv
/* Testbench for the execute core: runs small programs.
   Assumes the core, its checker and the memory model are compiled. */
`include "cex_defs.svh"
module test_cpu_instruction_execute_subset;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, reg_wr, reg_rd, prog_re, file_re, file_we;
	logic wdt_clr, to_n, pd_n;
	logic [3:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, file_addr;
	logic [14:0] prog_addr;
	logic [13:0] prog_data;
	logic [7:0]  file_wdata, file_rdata;
	int mismatches, check_count, wdt_count;
	cex_core dut_u (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .prog_addr(prog_addr), .prog_re(prog_re),
		.prog_data(prog_data), .file_addr(file_addr), .file_re(file_re),
		.file_we(file_we), .file_wdata(file_wdata),
		.file_rdata(file_rdata), .watchdog_clear(wdt_clr),
		.timeout_flag_n(to_n), .powerdown_flag_n(pd_n));
	cex_mem_model mem_u (.clk(clk), .prog_addr(prog_addr),
		.prog_re(prog_re), .prog_data(prog_data), .file_addr(file_addr),
		.file_re(file_re), .file_we(file_we), .file_wdata(file_wdata),
		.file_rdata(file_rdata));
	always @(posedge clk) wdt_count += wdt_clr;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h not %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe.
	task automatic rchk(input logic [3:0] a, input logic [15:0] m, e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		check(reg_rdata & m, e);
	endtask
	task automatic do_reset(input logic [13:0] p [8]);
		@(posedge clk);
		rstn <= 1'b0;
		foreach (p[i]) mem_u.rom[i] = p[i];
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
	endtask
	// Runs until n fetches are seen, then stops the core.
	task automatic run(input int n);
		int seen;
		seen = 0;
		wr(`CEX_REG_CTRL, 16'h0001);
		for (int i = 0; i < 2000 && seen < n; i++) begin
			@(posedge clk);
			seen += prog_re;
		end
		if (seen < n) begin
			mismatches++;
			tally_and_finish();
		end
		wr(`CEX_REG_CTRL, 16'h0000);
		repeat (16) @(posedge clk);
	endtask
	task automatic t_alu;
		do_reset('{14'h380f, 14'h04a0, 14'h09a1, 14'h3521, 14'h0ba2,
			14'h3880, 14'h17a3, 14'h2807});
		mem_u.ram[8'h20] = 8'h30;
		mem_u.ram[8'h21] = 8'h5a;
		mem_u.ram[8'h22] = 8'h01;
		mem_u.ram[8'h23] = 8'h00;
		run(9);
		check({8'h00, mem_u.ram[8'h20]}, 16'h003f);
		check({8'h00, mem_u.ram[8'h21]}, 16'h00a5);
		check({8'h00, mem_u.ram[8'h22]}, 16'h0000);
		check({8'h00, mem_u.ram[8'h23]}, 16'h0080);
		rchk(`CEX_REG_WORK, 16'hffff, 16'h004a);
		rchk(`CEX_REG_STATUS, 16'h001d, 16'h0019);
		$display("alu test done");
	endtask
	task automatic t_ind;
		do_reset('{14'h0010, 14'h0100, 14'h3202, 14'h3801, 14'h0010,
			14'h0013, 14'h2806, 14'h2806});
		mem_u.ram[8'h00] = 8'h77;
		wr(`CEX_REG_PTR0, 16'hffff);
		run(7);
		rchk(`CEX_REG_WORK, 16'hffff, 16'h0077);
		rchk(`CEX_REG_PTR0, 16'hffff, 16'hffff);
		rchk(`CEX_REG_STATUS, 16'h001c, 16'h0018);
		$display("indirect test done");
	endtask
	task automatic t_call;
		do_reset('{14'h0064, 14'h2010, 14'h0000, 14'h0000, 14'h0000,
			14'h0000, 14'h0000, 14'h0000});
		mem_u.rom[8'h10] = 14'h2810;
		wr(`CEX_REG_LATCH, 16'h0008);
		wdt_count = 0;
		run(4);
		rchk(`CEX_REG_TOS, 16'hffff, 16'h0002);
		rchk(`CEX_REG_PC, 16'hffff, 16'h0810);
		check(wdt_count[15:0], 16'h0001);
		check({14'h0000, pd_n, to_n}, 16'h0003);
		$display("call test done");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		{rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		t_alu();
		t_ind();
		t_call();
		tally_and_finish();
	end
endmodule // test_cpu_instruction_execute_subset
